// File: rtl/ocs_oscillator_clock_select.sv
// Chosen here: the AXI4-Lite register port.
module ocs_oscillator_clock_select (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic [31:0]        awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  input  wire logic [31:0]        araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  input  wire logic               oscInputPin,
  input  wire logic               oscEnableFromSysint,
  input  wire logic               stopMode,
  input  wire logic               waitMode,
  input  wire logic               breakState,
  input  wire logic               portABitSixOut,
  input  wire logic               portABitSixOe,
  output logic                    portABitSixIn,
  output ocs_pkg::ocs_pin_t       oscOutputPin,
  output logic                    crystalClock,
  output logic                    resistorCapClock,
  output ocs_pkg::ocs_clocks_t    clocks
);
  import ocs_pkg::*;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RESP = 2'b10
  } ocs_wstate_t;

  // Erased cell state at power-up; nrst never touches it
  logic [7:0]  optionByte_reg = OPTION_ERASED;
  logic [7:0]  pullup_reg;
  logic [7:0]  config_reg;
  logic        awHeld_reg;
  logic [31:0] awAddr_reg;
  logic        wHeld_reg;
  logic [31:0] wData_reg;
  logic [3:0]  wStrb_reg;
  ocs_wstate_t wState_reg;
  logic        crystalSel;
  logic        srcRun;
  logic        fullRate;
  logic        halfRate_reg;
  logic        halfClr_n;
  logic [15:0] slowCnt_reg;
  logic        slowClk_reg;
  logic        slowRun;

  function automatic logic [31:0] readMux(input logic [31:0] a, input logic [7:0] opt,
                                          input logic [7:0] pu, input logic [7:0] cf,
                                          input logic [31:0] st);
    if (a == ADDR_PULLUP) begin
      readMux = {24'h000000, pu};
    end else if (a == ADDR_OPTION) begin
      readMux = {24'h000000, opt};
    end else if (a == ADDR_CONFIG_TWO) begin
      readMux = {24'h000000, cf};
    end else begin
      readMux = st;
    end
  endfunction : readMux

  function automatic logic isMapped(input logic [31:0] a);
    isMapped = (a == ADDR_PULLUP) || (a == ADDR_OPTION) || (a == ADDR_CONFIG_TWO) || (a == ADDR_STATUS);
  endfunction : isMapped

  // Write channel capture; address and data may arrive in either order
  assign awready = !awHeld_reg && (wState_reg == BUS_IDLE);
  assign wready  = !wHeld_reg && (wState_reg == BUS_IDLE);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= 32'h00000000;
      wHeld_reg  <= 1'b0;
      wData_reg  <= 32'h00000000;
      wStrb_reg  <= 4'h0;
      wState_reg <= BUS_IDLE;
      bvalid     <= 1'b0;
      bresp      <= RESP_OKAY;
    end else begin
      case (wState_reg)
        BUS_IDLE: begin
          if (awvalid && awready) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= awaddr;
          end
          if (wvalid && wready) begin
            wHeld_reg <= 1'b1;
            wData_reg <= wdata;
            wStrb_reg <= wstrb;
          end
          if (awHeld_reg && wHeld_reg) begin
            awHeld_reg <= 1'b0;
            wHeld_reg  <= 1'b0;
            bvalid     <= 1'b1;
            bresp      <= isMapped(awAddr_reg) ? RESP_OKAY : RESP_SLVERR;
            wState_reg <= BUS_RESP;
          end
        end
        BUS_RESP: begin
          if (bready) begin
            bvalid     <= 1'b0;
            wState_reg <= BUS_IDLE;
          end
        end
        default: wState_reg <= BUS_IDLE;
      endcase
    end
  end

  logic doWrite;
  assign doWrite = (wState_reg == BUS_IDLE) && awHeld_reg && wHeld_reg && wStrb_reg[0];

  // The option byte models non-volatile storage, so no reset branch
  always_ff @(posedge clk) begin
    if (doWrite && awAddr_reg == ADDR_OPTION) begin
      optionByte_reg <= wData_reg[7:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pullup_reg <= PULLUP_RESET;
      config_reg <= CONFIG_RESET;
    end else if (doWrite) begin
      if (awAddr_reg == ADDR_PULLUP) begin
        pullup_reg <= wData_reg[7:0];
      end else if (awAddr_reg == ADDR_CONFIG_TWO) begin
        config_reg <= wData_reg[7:0];
      end
    end
  end

  // Read channel
  assign arready = !rvalid;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= isMapped(araddr) ? readMux(araddr, optionByte_reg, pullup_reg, config_reg,
                                           {28'h0000000, slowRun, srcRun, crystalSel, halfRate_reg})
                                 : 32'h00000000;
      rresp  <= isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Source selection; wait and break do not gate anything
  assign crystalSel = optionByte_reg[OPT_SEL_BIT];
  assign srcRun     = oscEnableFromSysint && !stopMode;

  assign crystalClock     = crystalSel && srcRun && oscInputPin;
  assign resistorCapClock = !crystalSel && srcRun && oscInputPin;
  assign fullRate         = crystalClock | resistorCapClock;

  // Half rate is a toggle of the source; cleared while the source is off so a restart starts low
  assign halfClr_n = nrst && srcRun;

  always_ff @(posedge fullRate or negedge halfClr_n) begin
    if (!halfClr_n) begin
      halfRate_reg <= 1'b0;
    end else begin
      halfRate_reg <= !halfRate_reg;
    end
  end

  // Internal slow clock from the system clock; restarts from reset with no setup
  assign slowRun = !(stopMode && config_reg[CFG_STOPDIS_BIT]);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      slowCnt_reg <= 16'h0000;
      slowClk_reg <= 1'b0;
    end else if (slowCnt_reg == 16'(SLOW_HALF_CYC - 1)) begin
      slowCnt_reg <= 16'h0000;
      slowClk_reg <= !slowClk_reg;
    end else begin
      slowCnt_reg <= slowCnt_reg + 16'h0001;
    end
  end

  assign clocks.fullRate       = fullRate;
  assign clocks.halfRate       = halfRate_reg && srcRun;
  assign clocks.slowClk        = slowClk_reg;
  assign clocks.slowToWatchdog = slowClk_reg && slowRun;

  // Shared output pin
  always_comb begin
    if (crystalSel) begin
      oscOutputPin.out = !oscInputPin && srcRun;
      oscOutputPin.oe  = 1'b1;
    end else if (!pullup_reg[PULLUP_OVR_BIT]) begin
      oscOutputPin.out = resistorCapClock;
      oscOutputPin.oe  = 1'b1;
    end else begin
      oscOutputPin.out = portABitSixOut;
      oscOutputPin.oe  = portABitSixOe;
    end
  end

  assign portABitSixIn = (!crystalSel && pullup_reg[PULLUP_OVR_BIT]) ? oscInputPin : 1'b0;
endmodule : ocs_oscillator_clock_select

// File: rtl/ocs_pkg.sv
package ocs_pkg;
  localparam logic [31:0] IDX_PULLUP       = 32'h0000000d;
  localparam logic [31:0] IDX_OPTION       = 32'h0000ffd0;
  localparam logic [31:0] ADDR_PULLUP      = IDX_PULLUP * 4;
  localparam logic [31:0] ADDR_OPTION      = IDX_OPTION * 4;
  localparam logic [31:0] ADDR_CONFIG_TWO  = 32'h00000100;
  localparam logic [31:0] ADDR_STATUS      = 32'h00000104;
  localparam int          OPT_SEL_BIT      = 7;
  localparam int          PULLUP_OVR_BIT   = 6;
  localparam int          CFG_STOPDIS_BIT  = 0;
  localparam logic [7:0]  OPTION_ERASED    = 8'hff;
  localparam logic [7:0]  PULLUP_RESET     = 8'h00;
  localparam logic [7:0]  CONFIG_RESET     = 8'h00;
  localparam int          CLK_HZ           = 25000000;
  localparam int          SLOW_HZ          = 50000;
  localparam int          SLOW_HALF_CYC    = CLK_HZ / (2 * SLOW_HZ);
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  typedef struct packed {
    logic fullRate;
    logic halfRate;
    logic slowClk;
    logic slowToWatchdog;
  } ocs_clocks_t;

  typedef struct packed {
    logic out;
    logic oe;
  } ocs_pin_t;
endpackage : ocs_pkg

// File: verification/ocs_osc_parts.sv
module ocs_osc_parts (
  input wire logic run,
  output logic     osc
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pin rests low while the amplifier is off; the 5 ns offset keeps every edge clear of both clk edges
  initial begin
    osc = 1'b0;
    #5;
    forever #310 osc = run ? !osc : 1'b0;
  end
endmodule : ocs_osc_parts

// File: verification/ocs_props.sv
module ocs_props
  import ocs_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 nrst,
  input wire logic                 oscInputPin,
  input wire logic                 oscEnableFromSysint,
  input wire logic                 stopMode,
  input wire logic                 crystalClock,
  input wire logic                 resistorCapClock,
  input wire ocs_pkg::ocs_clocks_t clocks
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] cnt;
  logic       prevSlow;
  logic       seen;
  logic       tog;
  assign tog = clocks.slowClk != prevSlow;
  // First phase after reset is only bounded, its start is not aligned
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {cnt, prevSlow, seen} <= '0;
    end else begin
      {prevSlow, seen} <= {clocks.slowClk, seen | tog};
      cnt <= tog ? 9'h000 : cnt + 9'h001;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  full_rate_a: assert property (
    oscEnableFromSysint && !stopMode |-> clocks.fullRate == oscInputPin) else $error("full rate differs");
  src_excl_a: assert property (
    !(crystalClock && resistorCapClock)) else $error("both sources run");
  stop_gate_a: assert property (
    stopMode |-> !clocks.fullRate && !clocks.halfRate && !crystalClock && !resistorCapClock) else $error("stop leak");
  en_gate_a: assert property (
    !oscEnableFromSysint |-> !clocks.fullRate && !clocks.halfRate && !crystalClock) else $error("disable leak");
  half_rate_a: assert property (
    $rose(clocks.halfRate) |-> clocks.fullRate) else $error("half rate off full edge");
  slow_period_a: assert property (
    tog && seen |-> cnt == 9'(SLOW_HALF_CYC - 1)) else $error("slow clock half period");
  slow_run_a: assert property (
    cnt <= 9'(SLOW_HALF_CYC)) else $error("slow clock stalled");
  wdog_clk_a: assert property (
    !stopMode |-> clocks.slowToWatchdog == clocks.slowClk) else $error("watchdog clock gated");
  cover property (stopMode && clocks.slowToWatchdog);
  cover property ($rose(clocks.halfRate));
  cover property (resistorCapClock);
endmodule : ocs_props

// File: verification/test_oscillator_clock_select.sv
module test_oscillator_clock_select import ocs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        nrst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic        oscEnableFromSysint, stopMode, waitMode, breakState, portABitSixOut, portABitSixOe;
  logic        portABitSixIn, crystalClock, resistorCapClock, oscInputPin, hi;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  ocs_clocks_t clocks;
  ocs_pin_t    oscOutputPin;
  int          fail_count, n_checks;
  logic [1:0]  bq[$];
  logic [33:0] rq[$];
  always #20 clk = !clk;
  ocs_oscillator_clock_select i_ocs_oscillator_clock_select (.clk, .nrst, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .oscInputPin, .oscEnableFromSysint, .stopMode, .waitMode, .breakState, .portABitSixOut,
    .portABitSixOe, .portABitSixIn, .oscOutputPin, .crystalClock, .resistorCapClock, .clocks);
  ocs_osc_parts i_ocs_osc_parts (.run(oscEnableFromSysint), .osc(oscInputPin));
  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  // Write or read one word; the expected answer goes to the queue first
  task automatic xfer(input bit w, input logic [31:0] a, input logic [31:0] v, input logic [1:0] r);
    if (w) bq.push_back(r);
    else rq.push_back({v, r});
    @(posedge clk);
    {awaddr, araddr, wdata} <= {a, a, v};
    {awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, !w, !w};
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
    end while (!(w ? bvalid : rvalid));
    {bready, rready} <= 2'b00;
  endtask : xfer
  task automatic wd_seen(output logic h);
    h = 1'b0;
    repeat (600) begin
      @(negedge clk);
      h |= clocks.slowToWatchdog;
    end
    @(posedge clk);
  endtask : wd_seen
  always @(posedge clk) begin
    if (bvalid && bready) check("bresp", {32'h0, bresp}, {32'h0, bq.pop_front()});
    if (rvalid && rready) check("rdata", {rdata, rresp}, rq.pop_front());
  end
  initial begin
    {nrst, awvalid, wvalid, bready, arvalid, rready, stopMode, waitMode, breakState} = '0;
    {oscEnableFromSysint, portABitSixOut, portABitSixOe, awaddr, wdata, araddr} = '0;
    wstrb = 4'hf;
    void'($urandom(32'h73cf));
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    xfer(0, ADDR_OPTION, {24'h0, OPTION_ERASED}, RESP_OKAY);
    xfer(0, ADDR_CONFIG_TWO, 32'h0, RESP_OKAY);
    xfer(0, 32'h00000200, 32'h0, RESP_SLVERR);
    {oscEnableFromSysint, portABitSixOut, portABitSixOe, waitMode, breakState} <= 5'h1f;
    repeat (40) @(negedge clk);
    check("crystal pin", {oscOutputPin.oe, portABitSixIn, resistorCapClock, crystalClock, oscOutputPin.out},
          {3'b100, oscInputPin, !oscInputPin});
    $display("test crystal done");
    xfer(1, ADDR_OPTION, 32'h7f, RESP_OKAY);
    repeat (20) begin
      @(negedge clk);
      check("rc pin", {oscOutputPin, crystalClock, resistorCapClock}, {oscInputPin, 2'b10, oscInputPin});
    end
    d = ($urandom & 32'hff) | 32'h40;
    xfer(1, ADDR_PULLUP, d, RESP_OKAY);
    wstrb <= 4'he;
    xfer(1, ADDR_PULLUP, 32'h0, RESP_OKAY);
    wstrb <= 4'hf;
    xfer(0, ADDR_PULLUP, d, RESP_OKAY);
    repeat (8) begin
      @(posedge clk);
      {portABitSixOut, portABitSixOe} <= 2'($urandom);
      @(negedge clk);
      check("port pin", {oscOutputPin.oe, oscOutputPin.out & oscOutputPin.oe, portABitSixIn},
            {portABitSixOe, portABitSixOut & portABitSixOe, oscInputPin});
    end
    $display("test rc done");
    @(posedge clk);
    nrst <= 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    xfer(0, ADDR_OPTION, 32'h7f, RESP_OKAY);
    xfer(0, ADDR_PULLUP, {24'h0, PULLUP_RESET}, RESP_OKAY);
    stopMode <= 1'b1;
    wd_seen(hi);
    check("watchdog in stop", {33'h0, hi}, 34'h1);
    oscEnableFromSysint <= 1'b0;
    @(posedge clk);
    stopMode <= 1'b0;
    xfer(1, ADDR_CONFIG_TWO, 32'h1, RESP_OKAY);
    repeat (8) @(posedge clk);
    oscEnableFromSysint <= 1'b1;
    repeat (20) @(posedge clk);
    stopMode <= 1'b1;
    wd_seen(hi);
    check("watchdog gated", {33'h0, hi}, 34'h0);
    $display("test stop done");
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
endmodule : test_oscillator_clock_select
bind ocs_oscillator_clock_select ocs_props i_ocs_props (.clk, .nrst, .oscInputPin, .oscEnableFromSysint,
  .stopMode, .crystalClock, .resistorCapClock, .clocks);
